/* File: qmsc_map.svh */
// qmsc_map.svh: opcodes, register offsets, field positions, reset values, timing
// assumes inclusion by bare name from the block's source file
`ifndef QMSC_MAP_SVH
`define QMSC_MAP_SVH
// opcodes
`define QMSC_QUAD_MODE_ENTER_CMD 8'h35
`define QMSC_QUAD_MODE_EXIT_CMD 8'hF5
`define QMSC_SUSPEND_CMD_A 8'h75
`define QMSC_SUSPEND_CMD_B 8'hB0
`define QMSC_RESUME_CMD_A 8'h7A
`define QMSC_RESUME_CMD_B 8'h30
`define QMSC_WRITE_ENABLE_CMD 8'h06
`define QMSC_WRITE_DISABLE_CMD 8'h04
`define QMSC_WRITE_STATUS_CMD 8'h01
`define QMSC_SERIAL_PROGRAM_CMD 8'h02
`define QMSC_QUAD_PROGRAM_CMD_A 8'h32
`define QMSC_QUAD_PROGRAM_CMD_B 8'h38
`define QMSC_RESET_ARM_CMD 8'h66
`define QMSC_SOFT_RESET_CMD 8'h99
// register offsets (byte addresses)
`define QMSC_CTRL_OFS 8'h00
`define QMSC_STATUS_OFS 8'h04
`define QMSC_FUNC_OFS 8'h08
`define QMSC_OP_LEN_OFS 8'h0C
`define QMSC_OP_ADDR_OFS 8'h10
`define QMSC_LAST_CMD_OFS 8'h14
// field positions
`define QMSC_CTRL_START_BIT 0
`define QMSC_CTRL_KIND_LSB 1
`define QMSC_CTRL_STATE_LSB 4
`define QMSC_STATUS_WIP_BIT 0
`define QMSC_STATUS_WEL_BIT 1
`define QMSC_STATUS_QUAD_BIT 6
`define QMSC_FUNC_PROGRAM_SUSPENDED_FLAG_BIT 2
`define QMSC_FUNC_ERASE_SUSPENDED_FLAG_BIT 3
`define QMSC_LAST_ACCEPT_BIT 8
// reset values
`define QMSC_OP_LEN_RST 16'h0100
`define QMSC_OP_ADDR_RST 24'h000000
// timing
`define QMSC_CLK_MHZ 50
`define QMSC_SUSPEND_LATENCY_US 100
`define QMSC_SUSPEND_LATENCY_CYC (`QMSC_SUSPEND_LATENCY_US * `QMSC_CLK_MHZ)
`endif

/* File: qmsc_pkg.sv */
// qmsc_pkg.sv: types shared by the quad mode and suspend controller
// assumes constants come from qmsc_map.svh
package qmsc_pkg;
  typedef enum logic [1:0] {KIND_SECTOR, KIND_BLOCK, KIND_PAGE, KIND_CHIP} qmsc_kind_t;
  typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_SUS_WAIT, OP_SUSPENDED} qmsc_opst_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } qmsc_cmd_t;
endpackage

/* File: qmsc_top.sv */
// qmsc_top.sv: serial flash command front end, quad mode switch, suspend/resume
// assumes CE_N, SCK, IO_IN come from the host asynchronously; SCK far below REF_CLK/4
//
// How it works
// RULE1: quad-enter opcode makes later frames four-bit
// RULE2: quad-exit opcode returns to one-bit frames
// RULE3: quad-exit honoured only as two-clock quad cycle
// RULE4: host frames quad-exit with chip enable
// RULE5: sector, block, page operations can be suspended
// RULE6: two suspend, two resume opcodes, both modes
// RULE7: function bit2 program, bit3 erase suspended
// RULE8: commands refused during suspend latency
// RULE9: host polls in-progress or waits latency
// RULE10: suspend ignored during chip erase
// RULE11: erase suspend refuses status write, erase, region
// RULE12: program suspend refuses status write, program, page
// RULE13: erase suspend sets flag, clears write latch
// RULE14: program suspend sets flag, clears write latch
// RULE15: resume restarts operation, clears suspend flag
// RULE16: quad cycle is two nibbles, high first
// RULE17: host waits 400us before next erase suspend
// RULE18: array reads accepted during any suspend
// RULE19: erase suspend also allows program, enable, lock
// RULE20: register, id, parameter, resume commands always allowed
// RULE21: soft reset only right after reset arm
// RULE22: host polls in-progress after resume
// RULE23: in-progress high while running, low when done
// RULE24: disallowed opcodes during suspend change nothing
// RULE25: suspend with nothing running has no effect
`include "qmsc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module qmsc_top
  import qmsc_pkg::*;
#(
  parameter int unsigned SUS_CYCLES = `QMSC_SUSPEND_LATENCY_CYC
)(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE_N,
  input wire logic SCK,
  input wire logic [3:0] IO_IN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RD_DATA,
  output logic IN_PROGRESS_FLAG,
  output logic WRITE_ENABLE_LATCH,
  output logic QUAD_MODE,
  output logic PROG_SUSPENDED,
  output logic ERASE_SUSPENDED,
  output logic CMD_ACCEPT,
  output logic CMD_REFUSE,
  output qmsc_cmd_t CMD_OUT
);

  function automatic logic f_is_read(input logic [7:0] op);
    case (op)
      8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED: f_is_read = 1'b1;
      default: f_is_read = 1'b0;
    endcase
  endfunction

  // set of opcodes that pass while an operation is suspended
  function automatic logic f_allowed(input logic [7:0] op, input logic erase_sus);
    case (op)
      8'h05, 8'h48, 8'h82, 8'h7A, 8'h30, 8'hAB, 8'hC0, 8'h63, 8'h83, 8'h61, 8'h81,
      8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A, 8'h00, 8'h66, 8'h99, 8'h68, 8'h14:
        f_allowed = 1'b1; // RULE20
      8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hB0, 8'h26, 8'h24:
        f_allowed = erase_sus; // RULE19
      default:
        f_allowed = f_is_read(op); // RULE18
    endcase
  endfunction

  // address lies in the sector, block or page that is being worked on
  function automatic logic f_in_region(input logic [23:0] a, input logic [23:0] base,
                                       input qmsc_kind_t kind);
    case (kind)
      KIND_SECTOR: f_in_region = (a[23:12] == base[23:12]);
      KIND_BLOCK: f_in_region = (a[23:16] == base[23:16]);
      KIND_PAGE: f_in_region = (a[23:8] == base[23:8]);
      default: f_in_region = 1'b1;
    endcase
  endfunction

  // pin synchronisers: {ce_n, sck, io[3:0]}
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic sck_prev;
  logic ce_prev;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1 <= 6'h20;
      sync2 <= 6'h20;
      sck_prev <= 1'b0;
      ce_prev <= 1'b1;
    end
    else
    begin
      sync1 <= {CE_N, SCK, IO_IN};
      sync2 <= sync1;
      sck_prev <= sync2[4];
      ce_prev <= sync2[5];
    end
  end

  logic ce_n_s;
  logic sck_rise;
  logic frame_start;
  logic frame_end;
  assign ce_n_s = sync2[5];
  assign sck_rise = sync2[4] & ~sck_prev & ~ce_n_s;
  assign frame_start = ~ce_n_s & ce_prev;
  assign frame_end = ce_n_s & ~ce_prev;

  // frame shifter
  logic [31:0] shreg;
  logic [5:0] bit_cnt;
  logic [7:0] opcode;
  logic [23:0] cmd_addr;
  logic [31:0] next_shreg;
  logic [5:0] next_cnt;

  always_comb
  begin
    if (QUAD_MODE)
    begin
      next_shreg = {shreg[27:0], sync2[3:0]}; // RULE16
      next_cnt = bit_cnt + 6'h04;
    end
    else
    begin
      next_shreg = {shreg[30:0], sync2[0]};
      next_cnt = bit_cnt + 6'h01;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      shreg <= 32'h0;
      bit_cnt <= 6'h0;
      opcode <= 8'h0;
      cmd_addr <= 24'h0;
    end
    else if (frame_start)
    begin
      shreg <= 32'h0;
      bit_cnt <= 6'h0;
      cmd_addr <= 24'h0;
    end
    else if (sck_rise && bit_cnt < 6'h20)
    begin
      shreg <= next_shreg;
      bit_cnt <= next_cnt;
      if (next_cnt == 6'h08)
        opcode <= next_shreg[7:0]; // RULE3
      if (next_cnt == 6'h20)
        cmd_addr <= next_shreg[23:0];
    end
  end

  // operation state
  qmsc_opst_t st;
  qmsc_kind_t kind;
  logic [15:0] op_len;
  logic [23:0] op_addr;
  logic [15:0] op_cnt;
  logic [15:0] sus_cnt;
  logic reset_armed;

  logic have_op;
  logic is_suspend;
  logic is_resume;
  logic suspended;
  logic blocked_read;
  logic accept;
  logic sus_take;
  logic sw_start;
  logic op_done;

  assign have_op = bit_cnt >= 6'h08;
  assign is_suspend = (opcode == `QMSC_SUSPEND_CMD_A) || (opcode == `QMSC_SUSPEND_CMD_B); // RULE6
  assign is_resume = (opcode == `QMSC_RESUME_CMD_A) || (opcode == `QMSC_RESUME_CMD_B); // RULE6
  assign suspended = (st == OP_SUSPENDED);
  assign blocked_read = f_is_read(opcode) && f_in_region(cmd_addr, op_addr, kind); // RULE11 RULE12

  always_comb
  begin
    accept = have_op;
    if (st == OP_SUS_WAIT)
      accept = 1'b0; // RULE8
    else if (suspended && (!f_allowed(opcode, ERASE_SUSPENDED) || blocked_read))
      accept = 1'b0; // RULE11 RULE12 RULE24
    if (opcode == `QMSC_SOFT_RESET_CMD && !reset_armed)
      accept = 1'b0; // RULE21
    if (opcode == `QMSC_QUAD_MODE_EXIT_CMD && !QUAD_MODE)
      accept = 1'b0; // RULE3
  end

  // running, not chip erase, not already suspended: otherwise no effect
  assign sus_take = frame_end && accept && is_suspend && st == OP_RUN
                    && kind != KIND_CHIP; // RULE5 RULE10 RULE25
  assign sw_start = WR && ADDR == `QMSC_CTRL_OFS && WR_DATA[`QMSC_CTRL_START_BIT]
                    && st == OP_IDLE;
  assign op_done = (st == OP_RUN) && (op_cnt >= op_len);

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      st <= OP_IDLE;
      kind <= KIND_SECTOR;
      op_cnt <= 16'h0;
      sus_cnt <= 16'h0;
    end
    else
    begin
      case (st)
        OP_IDLE:
          if (sw_start)
          begin
            st <= OP_RUN;
            kind <= qmsc_kind_t'(WR_DATA[`QMSC_CTRL_KIND_LSB +: 2]);
            op_cnt <= 16'h0;
          end
        OP_RUN:
          if (sus_take)
          begin
            st <= OP_SUS_WAIT; // RULE5
            sus_cnt <= 16'h0;
          end
          else if (op_done)
            st <= OP_IDLE;
          else
            op_cnt <= op_cnt + 16'h1;
        OP_SUS_WAIT:
          if (sus_cnt == 16'(SUS_CYCLES - 1))
            st <= OP_SUSPENDED; // RULE8
          else
            sus_cnt <= sus_cnt + 16'h1;
        OP_SUSPENDED:
          if (frame_end && accept && is_resume)
            st <= OP_RUN; // RULE15
        default:
          st <= OP_IDLE;
      endcase
    end
  end

  // suspend flags
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      PROG_SUSPENDED <= 1'b0;
      ERASE_SUSPENDED <= 1'b0;
    end
    else if (sus_take)
    begin
      PROG_SUSPENDED <= (kind == KIND_PAGE); // RULE7 RULE14
      ERASE_SUSPENDED <= (kind != KIND_PAGE); // RULE7 RULE13
    end
    else if (suspended && frame_end && accept && is_resume)
    begin
      PROG_SUSPENDED <= 1'b0; // RULE15
      ERASE_SUSPENDED <= 1'b0;
    end
  end

  // write enable latch; an enable in the completion cycle wins
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      WRITE_ENABLE_LATCH <= 1'b0;
    else if (sus_take)
      WRITE_ENABLE_LATCH <= 1'b0; // RULE13 RULE14
    else if (frame_end && accept && opcode == `QMSC_WRITE_ENABLE_CMD)
      WRITE_ENABLE_LATCH <= 1'b1;
    else if (op_done || (frame_end && accept && opcode == `QMSC_WRITE_DISABLE_CMD))
      WRITE_ENABLE_LATCH <= 1'b0;
  end

  // interface mode and reset arming; only a reset returns to one-bit mode by itself
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      QUAD_MODE <= 1'b0;
      reset_armed <= 1'b0;
    end
    else if (frame_end && accept)
    begin
      if (opcode == `QMSC_QUAD_MODE_ENTER_CMD)
        QUAD_MODE <= 1'b1; // RULE1
      else if (opcode == `QMSC_QUAD_MODE_EXIT_CMD)
        QUAD_MODE <= 1'b0; // RULE2
      reset_armed <= (opcode == `QMSC_RESET_ARM_CMD); // RULE21
    end
  end

  // in-progress lags the state by one cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      IN_PROGRESS_FLAG <= 1'b0;
    else
      IN_PROGRESS_FLAG <= (st == OP_RUN) || (st == OP_SUS_WAIT); // RULE23
  end

  // command hand-off to the rest of the device
  logic last_accept;
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      CMD_ACCEPT <= 1'b0;
      CMD_REFUSE <= 1'b0;
      CMD_OUT <= '0;
      last_accept <= 1'b0;
    end
    else
    begin
      CMD_ACCEPT <= frame_end && accept;
      CMD_REFUSE <= frame_end && have_op && !accept; // RULE24
      if (frame_end && have_op)
      begin
        CMD_OUT <= {opcode, cmd_addr};
        last_accept <= accept;
      end
    end
  end

  // register port
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      op_len <= `QMSC_OP_LEN_RST;
      op_addr <= `QMSC_OP_ADDR_RST;
    end
    else if (WR && st == OP_IDLE)
    begin
      if (ADDR == `QMSC_OP_LEN_OFS)
        op_len <= WR_DATA[15:0];
      if (ADDR == `QMSC_OP_ADDR_OFS)
        op_addr <= WR_DATA[23:0];
    end
  end

  logic [31:0] next_rd;
  always_comb
  begin
    next_rd = 32'h0;
    case (ADDR)
      `QMSC_CTRL_OFS:
      begin
        next_rd[`QMSC_CTRL_KIND_LSB +: 2] = kind;
        next_rd[`QMSC_CTRL_STATE_LSB +: 2] = st;
      end
      `QMSC_STATUS_OFS:
      begin
        next_rd[`QMSC_STATUS_WIP_BIT] = IN_PROGRESS_FLAG;
        next_rd[`QMSC_STATUS_WEL_BIT] = WRITE_ENABLE_LATCH;
        next_rd[`QMSC_STATUS_QUAD_BIT] = QUAD_MODE;
      end
      `QMSC_FUNC_OFS:
      begin
        next_rd[`QMSC_FUNC_PROGRAM_SUSPENDED_FLAG_BIT] = PROG_SUSPENDED; // RULE7
        next_rd[`QMSC_FUNC_ERASE_SUSPENDED_FLAG_BIT] = ERASE_SUSPENDED;
      end
      `QMSC_OP_LEN_OFS: next_rd[15:0] = op_len;
      `QMSC_OP_ADDR_OFS: next_rd[23:0] = op_addr;
      `QMSC_LAST_CMD_OFS:
      begin
        next_rd[7:0] = CMD_OUT.opcode;
        next_rd[`QMSC_LAST_ACCEPT_BIT] = last_accept;
      end
      default: next_rd = 32'h0;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      RD_DATA <= 32'h0;
    else if (RD)
      RD_DATA <= next_rd;
    else
      RD_DATA <= 32'h0;
  end

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_sus_frame;
    frame_end && is_suspend && accept && st == OP_RUN && kind != KIND_CHIP;
  endsequence

  // short frames keep the old opcode, and suspension filters the enter opcode
  property p_quad_enter;
    frame_end && have_op && opcode == `QMSC_QUAD_MODE_ENTER_CMD && st != OP_SUS_WAIT
      && !suspended |=> QUAD_MODE;
  endproperty
  a_quad_enter: assert property (p_quad_enter) else $error("quad enter ignored"); // RULE1

  property p_quad_exit;
    frame_end && opcode == `QMSC_QUAD_MODE_EXIT_CMD && QUAD_MODE && accept |=> !QUAD_MODE;
  endproperty
  a_quad_exit: assert property (p_quad_exit) else $error("quad exit ignored"); // RULE2

  property p_exit_serial;
    frame_end && have_op && opcode == `QMSC_QUAD_MODE_EXIT_CMD && !QUAD_MODE
      |=> CMD_REFUSE && !QUAD_MODE;
  endproperty
  a_exit_serial: assert property (p_exit_serial) else $error("serial exit taken"); // RULE3

  property p_erase_sus;
    s_sus_frame ##0 (kind != KIND_PAGE) |=> ERASE_SUSPENDED && !WRITE_ENABLE_LATCH && !PROG_SUSPENDED
      ##1 IN_PROGRESS_FLAG;
  endproperty
  a_erase_sus: assert property (p_erase_sus) else $error("erase suspend wrong"); // RULE13

  property p_prog_sus;
    s_sus_frame ##0 (kind == KIND_PAGE) |=> PROG_SUSPENDED && !WRITE_ENABLE_LATCH && !ERASE_SUSPENDED;
  endproperty
  a_prog_sus: assert property (p_prog_sus) else $error("program suspend wrong"); // RULE14

  property p_sus_busy;
    st == OP_SUS_WAIT && frame_end && have_op |=> CMD_REFUSE && !CMD_ACCEPT;
  endproperty
  a_sus_busy: assert property (p_sus_busy) else $error("command taken in latency"); // RULE8

  property p_chip_no_sus;
    frame_end && is_suspend && st == OP_RUN && kind == KIND_CHIP |=> st == OP_RUN
      || st == OP_IDLE;
  endproperty
  a_chip_no_sus: assert property (p_chip_no_sus) else $error("chip erase suspended"); // RULE10

  property p_resume;
    suspended && frame_end && is_resume && accept
      |=> st == OP_RUN && !PROG_SUSPENDED && !ERASE_SUSPENDED ##1 IN_PROGRESS_FLAG;
  endproperty
  a_resume: assert property (p_resume) else $error("resume failed"); // RULE15

  property p_filter;
    suspended && frame_end && have_op && !f_allowed(opcode, ERASE_SUSPENDED)
      |=> CMD_REFUSE && $stable(st) && $stable(WRITE_ENABLE_LATCH) && $stable(QUAD_MODE);
  endproperty
  a_filter: assert property (p_filter) else $error("disallowed opcode acted"); // RULE24

  property p_soft_reset;
    frame_end && have_op && opcode == `QMSC_SOFT_RESET_CMD && !reset_armed |=> CMD_REFUSE;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("unarmed reset taken"); // RULE21

  property p_idle_sus;
    frame_end && is_suspend && st == OP_IDLE && !sw_start |=> st == OP_IDLE
      && $stable(PROG_SUSPENDED) && $stable(ERASE_SUSPENDED) && $stable(WRITE_ENABLE_LATCH);
  endproperty
  a_idle_sus: assert property (p_idle_sus) else $error("idle suspend acted"); // RULE25

  property p_wip;
    st == OP_RUN |=> IN_PROGRESS_FLAG;
  endproperty
  a_wip: assert property (p_wip) else $error("in-progress low while running"); // RULE23

endmodule
`default_nettype wire

/* File: qmsc_host_model.sv */
// qmsc_host_model.sv: serial flash host driving chip enable, link clock and data pins
// assumes ref_clk is the bench clock; the link clock runs at eight ref_clk periods
`timescale 1ns/100ps
`default_nettype none
module qmsc_host_model (
  input wire logic ref_clk,
  output logic ce_n,
  output logic sck,
  output logic [3:0] io
);
  initial
  begin
    ce_n = 1'b1;
    sck = 1'b0;
    io = 4'hA;
  end

  // one framed transfer; link clock stands still low outside frames
  task automatic frame(input bit quad, input int nbits, input logic [31:0] data);
    int units;
    int step;
    logic [31:0] sh;
    units = quad ? nbits / 4 : nbits;
    step = quad ? 4 : 1;
    sh = data;
    @(posedge ref_clk);
    ce_n <= 1'b0;
    for (int i = 0; i < units; i++)
    begin
      // spare pins toggle in serial mode so nothing relies on them
      io <= quad ? sh[31:28] : {~sh[30:28], sh[31]};
      sh = sh << step;
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    ce_n <= 1'b1;
    // released pins carry no pull, so show the inverse
    io <= ~io;
  endtask
endmodule
`default_nettype wire

/* File: qmsc_top_test.sv */
// qmsc_top_test.sv: self-checking bench for the quad mode and suspend controller
// assumes qmsc_pkg, qmsc_map.svh and the host model are compiled first
`include "qmsc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module qmsc_top_test import qmsc_pkg::*; ;
  localparam int SUS = 60;
  localparam int OPLEN = 3000;
  localparam int LIMIT = 60000;
  localparam logic [23:0] OPADDR = 24'h012345;
  logic ref_clk;
  logic rst;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic ce_n;
  logic sck;
  logic [3:0] io;
  logic [31:0] rd_data;
  logic in_progress_flag;
  logic write_enable_latch;
  logic quad_mode;
  logic program_suspended_flag;
  logic erase_suspended_flag;
  logic acc;
  logic rfs;
  qmsc_cmd_t cmd_out;
  logic [31:0] d;
  int m_quad;
  int m_state;
  int m_kind;
  int m_wel;
  int m_program_suspended_flag;
  int m_erase_suspended_flag;
  int m_armed;
  int miscompares;
  int num_checks;
  int cycles = 0;

  // sus latency shortened so a quad frame still lands inside it
  qmsc_top #(.SUS_CYCLES(SUS)) dut (.REF_CLK(ref_clk), .RST(rst), .CE_N(ce_n), .SCK(sck),
    .IO_IN(io), .ADDR(addr), .WR_DATA(wr_data), .WR(wr), .RD(rd), .RD_DATA(rd_data),
    .IN_PROGRESS_FLAG(in_progress_flag), .WRITE_ENABLE_LATCH(write_enable_latch), .QUAD_MODE(quad_mode), .PROG_SUSPENDED(program_suspended_flag),
    .ERASE_SUSPENDED(erase_suspended_flag), .CMD_ACCEPT(acc), .CMD_REFUSE(rfs), .CMD_OUT(cmd_out));
  qmsc_host_model host (.ref_clk(ref_clk), .ce_n(ce_n), .sck(sck), .io(io));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      miscompares++;
      $display("[ERR] %0t run too long", $time);
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    {m_quad, m_state, m_kind, m_wel, m_program_suspended_flag, m_erase_suspended_flag, m_armed} = '0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({in_progress_flag, quad_mode, program_suspended_flag, erase_suspended_flag}, 4'h0);
    reg_wr(`QMSC_OP_LEN_OFS, OPLEN);
    reg_wr(`QMSC_OP_ADDR_OFS, {8'h00, OPADDR});
  endtask

  // reference model of acceptance and its side effects
  function automatic int decide(input logic [7:0] op, input logic [23:0] a);
    int hit;
    int ok;
    hit = (m_kind == 2) ? (a[23:8] == OPADDR[23:8]) :
      (m_kind == 1) ? (a[23:16] == OPADDR[23:16]) : (a[23:12] == OPADDR[23:12]);
    if (m_state == 2)
      ok = 0;
    else if (op == 8'hF5 && m_quad == 0)
      ok = 0;
    else if (op == 8'h99)
      ok = m_armed;
    else if (m_state == 3)
    begin
      ok = (op inside {8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED,
        8'h05, 8'h48, 8'h82, 8'h7A, 8'h30, 8'hAB, 8'hC0, 8'h63, 8'h83, 8'h61, 8'h81,
        8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A, 8'h00, 8'h66, 8'h68, 8'h14}) ||
        (m_erase_suspended_flag == 1 && op inside {8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hB0, 8'h26, 8'h24});
      if (hit == 1 && op inside {8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED})
        ok = 0;
    end
    else
      ok = 1;
    if (ok == 1)
    begin
      m_armed = (op == 8'h66);
      if (op == 8'h35)
        m_quad = 1;
      if (op == 8'hF5)
        m_quad = 0;
      if (op == 8'h06)
        m_wel = 1;
      if (op inside {8'h75, 8'hB0} && m_state == 1 && m_kind != 3)
      begin
        m_state = 2;
        m_wel = 0;
        m_program_suspended_flag = (m_kind == 2);
        m_erase_suspended_flag = (m_kind != 2);
      end
      if (op inside {8'h7A, 8'h30} && m_state == 3)
      begin
        m_state = 1;
        m_program_suspended_flag = 0;
        m_erase_suspended_flag = 0;
      end
    end
    return ok;
  endfunction

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nbits);
    int ok;
    int n;
    host.frame(m_quad[0], nbits, {op, a});
    ok = decide(op, a);
    n = 0;
    while (acc !== 1'b1 && rfs !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(acc, ok);
    check(rfs, ok == 0);
    check(quad_mode, m_quad);
    check(write_enable_latch, m_wel);
    check({program_suspended_flag, erase_suspended_flag}, {m_program_suspended_flag[0], m_erase_suspended_flag[0]});
    if (nbits == 32)
      check(cmd_out, {op, a});
    else
      check(cmd_out.opcode, op);
    @(posedge ref_clk);
    #1;
    check(in_progress_flag, m_state == 1 || m_state == 2);
    repeat (2) @(posedge ref_clk);
  endtask

  // the host polls the in-progress flag instead of guessing the time
  task automatic wait_wip(input int lim, input int nxt);
    int n;
    n = 0;
    while (in_progress_flag !== 1'b0 && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n < lim, 1);
    m_state = nxt;
    if (nxt == 0)
      m_wel = 0;
  endtask

  task automatic start(input int kind);
    reg_wr(`QMSC_CTRL_OFS, 32'(1 + kind * 2));
    m_kind = kind;
    m_state = 1;
    repeat (2) @(posedge ref_clk);
    #1;
    check(in_progress_flag, 1);
  endtask

  // mode and resume opcodes are left out: they are driven on purpose elsewhere
  task automatic rnd(input int count);
    logic [7:0] op;
    logic [23:0] a;
    for (int i = 0; i < count; i++)
    begin
      op = 8'($urandom_range(255));
      while (op inside {8'h35, 8'hF5, 8'h66, 8'h99, 8'h7A, 8'h30, 8'h75, 8'hB0, 8'h02, 8'h32, 8'h38})
        op = 8'($urandom_range(255));
      a = $urandom_range(1) ? (OPADDR ^ 24'($urandom_range(255))) : 24'($urandom);
      cmd(op, a, 32);
    end
  endtask

  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(32'hB90A6489));
    do_reset();
    reg_rd(8'h3C, d);
    check(d, 0);
    cmd(8'hF5, 24'h0, 8);
    cmd(8'h06, 24'h0, 8);
    start(0);
    cmd(8'h35, 24'h0, 8);
    cmd(8'h75, 24'h0, 8);
    cmd(8'h05, 24'h0, 8);
    wait_wip(SUS + 10, 3);
    reg_rd(`QMSC_FUNC_OFS, d);
    check(d[3:2], 2'b10);
    cmd(8'h03, OPADDR, 32);
    cmd(8'h06, 24'h0, 8);
    cmd(8'h75, 24'h0, 8);
    cmd(8'h01, 24'h0, 8);
    cmd(8'h20, OPADDR ^ 24'h010000, 32);
    rnd(40);
    cmd(8'h30, 24'h0, 8);
    cmd(8'hF5, 24'h0, 8);
    wait_wip(OPLEN + 100, 0);
    cmd(8'h75, 24'h0, 8);
    do_reset();
    cmd(8'h06, 24'h0, 8);
    start(2);
    cmd(8'hB0, 24'h0, 8);
    wait_wip(SUS + 10, 3);
    reg_rd(`QMSC_FUNC_OFS, d);
    check(d[3:2], 2'b01);
    cmd(8'h02, OPADDR ^ 24'h001000, 32);
    cmd(8'h03, OPADDR, 32);
    cmd(8'h06, 24'h0, 8);
    rnd(20);
    cmd(8'h7A, 24'h0, 8);
    wait_wip(OPLEN + 100, 0);
    start(3);
    cmd(8'hB0, 24'h0, 8);
    wait_wip(OPLEN + 100, 0);
    // block region is coarser than a sector: same block, other sector must be refused
    start(1);
    cmd(8'h75, 24'h0, 8);
    wait_wip(SUS + 10, 3);
    reg_wr(`QMSC_OP_LEN_OFS, 32'h5);
    reg_rd(`QMSC_OP_LEN_OFS, d);
    check(d, OPLEN);
    cmd(8'h03, OPADDR ^ 24'h00F000, 32);
    cmd(8'h03, OPADDR ^ 24'h100000, 32);
    cmd(8'h7A, 24'h0, 8);
    wait_wip(OPLEN + 100, 0);
    cmd(8'h99, 24'h0, 8);
    cmd(8'h66, 24'h0, 8);
    cmd(8'h99, 24'h0, 8);
    print_verdict();
  end
endmodule
`default_nettype wire
